/* core/dsc_ctl_decode.sv */
`timescale 1ns/1ps
`include "dsc_defines.svh"
// Drive-control byte decoder: edges, precedence, executability
module dsc_ctl_decode (
  // Control bytes, new and previous
  input wire logic [7:0] ctl_new,
  input wire logic [7:0] ctl_prev,
  // Current operating state
  input wire logic [3:0] drive_state,
  // Requests to issue, combinational
  output logic power_stage_off,
  output logic power_stage_on,
  output logic quick_stop_request,
  output logic fault_clear_request,
  output logic halt_set,
  output logic halt_clear,
  output logic halt_resume
);

  // Rising edges of the control byte
  wire [7:0] rise = ctl_new & ~ctl_prev;
  // Empty field counts as a disable
  wire all_zero = (ctl_new == 8'h00);
  // Executability per state
  wire st_run = (drive_state == `DSC_ST_OP_ENABLED);
  wire st_on = st_run || (drive_state == `DSC_ST_SWITCHED_ON) ||
               (drive_state == `DSC_ST_QSTOP_ACTIVE);
  wire st_ready = (drive_state == `DSC_ST_READY) ||
                  (drive_state == `DSC_ST_SWITCHED_ON);
  wire st_fault = (drive_state == `DSC_ST_FAULT) ||
                  (drive_state == `DSC_ST_QSTOP_ACTIVE);
  // Raw requests after precedence
  wire off_raw = rise[0] || all_zero;
  wire on_raw = rise[1] && !rise[0];
  wire stop_raw = rise[2];
  wire clr_raw = rise[3] && !rise[2];
  wire hset_raw = rise[5];
  wire hclr_raw = rise[6] && !rise[5];
  wire hres_raw = rise[7] && !rise[5];

  // Drop what the state cannot execute, silently
  assign power_stage_off = off_raw && st_on;
  assign power_stage_on = on_raw && st_ready;
  assign quick_stop_request = stop_raw && st_run;
  assign fault_clear_request = clr_raw && st_fault;
  assign halt_set = hset_raw && st_run;
  assign halt_clear = hclr_raw && st_run;
  assign halt_resume = hres_raw && st_run;

endmodule : dsc_ctl_decode

/* core/dsc_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for levels from outside the clock domain
module dsc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second
  logic [WIDTH-1:0] meta_q;

  // Two flops in series
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : dsc_sync

/* core/dsc_top.sv */
`timescale 1ns/1ps
`include "dsc_defines.svh"
// Parameter and cyclic command handling of the drive
module dsc_top (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Register access request from the fieldbus stack
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [2:0] REQ_COUNT,
  input wire logic [63:0] REQ_WDATA,
  input wire logic CHANNEL_OWNED,
  // Register access answer
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic RSP_ERROR,
  output logic [15:0] RSP_RDATA,
  // Pins from persistent storage and service tool
  input wire logic NV_ROT_SENSE,
  input wire logic FACTORY_REQ,
  // Drive status from the state machine and speed loop
  input wire logic [3:0] DRIVE_STATE,
  input wire logic SPEED_NEG,
  // Persistent storage control
  output logic NV_SAVE,
  output logic NV_SAVE_ROT_SENSE,
  output logic USER_RESTORE,
  output logic FACTORY_RESTORE,
  output logic REBOOT_PENDING,
  // Rotation
  output logic ROT_SENSE_EFFECTIVE,
  output logic MOTOR_CW,
  // Drive-control pulses
  output logic POWER_STAGE_OFF,
  output logic POWER_STAGE_ON,
  output logic QUICK_STOP_REQUEST,
  output logic FAULT_CLEAR_REQUEST,
  output logic HALT_SET,
  output logic HALT_CLEAR,
  output logic HALT_RESUME,
  // Mode data handed to the mode machine
  output logic MODE_STROBE,
  output logic [6:0] MODE_CMD,
  output logic [15:0] SHORT_REF,
  output logic [31:0] LONG_REF
);

  // Bus slave state
  dsc_pkg::dsc_bus_type bus_q;
  dsc_pkg::dsc_bus_type bus_d;

  // Synchronised pins
  logic nv_rot_s;
  logic factory_s;
  // Factory request edge memory
  logic factory_prev_q;
  // Boot capture done flag
  logic booted_q;
  // Synchroniser fill after reset release
  logic [1:0] settle_q;
  // Capture edge: pin value has passed both flops, not their reset
  wire boot_now = settle_q[1] && !booted_q;

  // Working copies of parameters
  logic rot_sense_q;
  logic [2:0] restore_q;
  // Previous command word, control and toggle parts
  logic [7:0] ctl_prev_q;
  logic tog_prev_q;
  // Long reference as last written
  logic [31:0] long_q;

  // Decoded control requests
  logic off_c;
  logic on_c;
  logic stop_c;
  logic clr_c;
  logic hset_c;
  logic hclr_c;
  logic hres_c;

  // Pins from outside pass two flops
  dsc_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .async_in({NV_ROT_SENSE, FACTORY_REQ}),
    .sync_out({nv_rot_s, factory_s})
  );

  // Request fields
  wire take = REQ_VALID && (bus_q == dsc_pkg::DSC_IDLE);
  wire [15:0] w_first = REQ_WDATA[63:48];
  wire [15:0] w_second = REQ_WDATA[47:32];
  wire [31:0] w_third = REQ_WDATA[31:0];

  // Address decode
  wire hit_restore = (REQ_ADDR == `DSC_ADDR_USER_RESTORE);
  wire hit_rot = (REQ_ADDR == `DSC_ADDR_ROT_SENSE);
  wire hit_cmd = (REQ_ADDR == `DSC_ADDR_CMD_SHORT);
  wire hit_long = (REQ_ADDR == `DSC_ADDR_LONG_REF);

  // Access width checks
  wire cnt_one = (REQ_COUNT == `DSC_CNT_ONE);
  wire cnt_pair = (REQ_COUNT == `DSC_CNT_PAIR);
  wire cnt_both = (REQ_COUNT == `DSC_CNT_BOTH);
  // Cyclic registers refuse anything but 32-bit words
  wire cmd_width_ok = cnt_pair || cnt_both;
  wire long_width_ok = cnt_pair;

  // Value range checks for parameter writes
  wire restore_ok = (w_first <= `DSC_RESTORE_MAX);
  wire rot_ok = (w_first <= `DSC_ROT_MAX);

  // Cyclic writes need the channel
  wire chan_ok = CHANNEL_OWNED;

  // Accepted write strobes
  wire wr_restore = take && REQ_WRITE && hit_restore && cnt_one &&
                    restore_ok;
  wire wr_rot = take && REQ_WRITE && hit_rot && cnt_one && rot_ok;
  wire wr_cmd = take && REQ_WRITE && hit_cmd && cmd_width_ok &&
                chan_ok;
  wire wr_long_only = take && REQ_WRITE && hit_long && long_width_ok &&
                      chan_ok;
  wire wr_long_both = wr_cmd && cnt_both;
  wire wr_long = wr_long_only || wr_long_both;

  // Accepted reads, parameters only
  wire rd_restore = take && !REQ_WRITE && hit_restore && cnt_one;
  wire rd_rot = take && !REQ_WRITE && hit_rot && cnt_one;

  // Anything else taken is an error
  wire req_ok = wr_restore || wr_rot || wr_cmd || wr_long_only ||
                rd_restore || rd_rot;
  wire req_err = take && !req_ok;

  // Read data mux
  wire [15:0] rd_data = rd_rot ? {15'h0000, rot_sense_q} :
                        rd_restore ? {13'h0000, restore_q} :
                        16'h0000;

  // Command word parts
  wire [7:0] ctl_new = w_first[15:8];
  wire [7:0] mode_byte = w_first[7:0];
  wire tog_new = mode_byte[`DSC_TOGGLE_BIT];
  // Mode data taken only on a toggle and a non-empty byte
  wire tog_changed = (tog_new != tog_prev_q);
  wire mode_empty = (mode_byte == 8'h00);
  wire mode_go = wr_cmd && tog_changed && !mode_empty;
  // Long reference paired with this command
  wire [31:0] long_use = cnt_both ? w_third : long_q;

  // Restore request from the restore register
  wire restore_go = wr_restore && w_first[`DSC_RESTORE_GO_BIT];
  // Factory request as a rising edge
  wire factory_go = factory_s && !factory_prev_q;

  // Bus slave next state
  always_comb begin
    bus_d = bus_q;
    unique case (bus_q)
      dsc_pkg::DSC_IDLE: begin
        if (REQ_VALID) begin
          bus_d = dsc_pkg::DSC_ANSWER;
        end
      end
      dsc_pkg::DSC_ANSWER: begin
        bus_d = dsc_pkg::DSC_IDLE;
      end
      default: begin
        bus_d = dsc_pkg::DSC_IDLE;
      end
    endcase
  end

  // Drive-control decoder
  dsc_ctl_decode u_ctl (
    .ctl_new(ctl_new),
    .ctl_prev(ctl_prev_q),
    .drive_state(DRIVE_STATE),
    .power_stage_off(off_c),
    .power_stage_on(on_c),
    .quick_stop_request(stop_c),
    .fault_clear_request(clr_c),
    .halt_set(hset_c),
    .halt_clear(hclr_c),
    .halt_resume(hres_c)
  );

  // Bus state and answer
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_q <= dsc_pkg::DSC_IDLE;
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_ERROR <= 1'b0;
      RSP_RDATA <= 16'h0000;
    end else begin
      bus_q <= bus_d;
      // Ready in the idle state only
      REQ_READY <= (bus_d == dsc_pkg::DSC_IDLE);
      RSP_VALID <= take;
      RSP_ERROR <= req_err;
      RSP_RDATA <= take ? rd_data : 16'h0000;
    end
  end

  // Power-up capture of persistent rotation sense
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      settle_q <= 2'b00;
      booted_q <= 1'b0;
      ROT_SENSE_EFFECTIVE <= `DSC_ROT_RESET;
    end else begin
      // Count the synchroniser full before trusting its output
      settle_q <= {settle_q[0], 1'b1};
      if (boot_now) begin
        // Only once after release; later writes wait for next power-up
        booted_q <= 1'b1;
        ROT_SENSE_EFFECTIVE <= nv_rot_s;
      end
    end
  end

  // Working rotation sense parameter
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rot_sense_q <= `DSC_ROT_RESET;
    end else if (boot_now) begin
      rot_sense_q <= nv_rot_s;
    end else if (factory_go) begin
      rot_sense_q <= `DSC_ROT_RESET;
    end else if (wr_rot) begin
      rot_sense_q <= w_first[0];
    end
  end

  // Restore register, holds the last written value
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      restore_q <= 3'h0;
    end else if (wr_restore) begin
      restore_q <= w_first[2:0];
    end
  end

  // Persistent storage strobes
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      NV_SAVE <= 1'b0;
      NV_SAVE_ROT_SENSE <= `DSC_ROT_RESET;
      USER_RESTORE <= 1'b0;
      FACTORY_RESTORE <= 1'b0;
      REBOOT_PENDING <= 1'b0;
      factory_prev_q <= 1'b0;
    end else begin
      factory_prev_q <= factory_s;
      // Rotation sense is persistent: save on write or factory reset
      NV_SAVE <= booted_q && (wr_rot || factory_go);
      if (factory_go) begin
        NV_SAVE_ROT_SENSE <= `DSC_ROT_RESET;
      end else if (wr_rot) begin
        NV_SAVE_ROT_SENSE <= w_first[0];
      end
      // User restore hits working storage only, never a save
      USER_RESTORE <= restore_go;
      FACTORY_RESTORE <= booted_q && factory_go;
      // Something waits for the next power cycle
      if (booted_q && (factory_go || wr_rot)) begin
        REBOOT_PENDING <= 1'b1;
      end
    end
  end

  // Motor sense from speed sign and effective setting
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      MOTOR_CW <= 1'b1;
    end else begin
      // Positive speed is clockwise unless inverted
      MOTOR_CW <= SPEED_NEG ^ ~ROT_SENSE_EFFECTIVE;
    end
  end

  // Previous control word, updated per accepted command write
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_prev_q <= 8'h00;
      tog_prev_q <= 1'b0;
    end else if (wr_cmd) begin
      ctl_prev_q <= ctl_new;
      tog_prev_q <= tog_new;
    end
  end

  // Long reference store
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      long_q <= 32'h0000_0000;
    end else if (wr_long) begin
      long_q <= cnt_both ? w_third : REQ_WDATA[63:32];
    end
  end

  // Drive-control pulses, one cycle per accepted edge
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      POWER_STAGE_OFF <= 1'b0;
      POWER_STAGE_ON <= 1'b0;
      QUICK_STOP_REQUEST <= 1'b0;
      FAULT_CLEAR_REQUEST <= 1'b0;
      HALT_SET <= 1'b0;
      HALT_CLEAR <= 1'b0;
      HALT_RESUME <= 1'b0;
    end else begin
      POWER_STAGE_OFF <= wr_cmd && off_c;
      POWER_STAGE_ON <= wr_cmd && on_c;
      QUICK_STOP_REQUEST <= wr_cmd && stop_c;
      FAULT_CLEAR_REQUEST <= wr_cmd && clr_c;
      HALT_SET <= wr_cmd && hset_c;
      HALT_CLEAR <= wr_cmd && hclr_c;
      HALT_RESUME <= wr_cmd && hres_c;
    end
  end

  // Mode data hand-over, consistent set per toggle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      MODE_STROBE <= 1'b0;
      MODE_CMD <= 7'h00;
      SHORT_REF <= 16'h0000;
      LONG_REF <= 32'h0000_0000;
    end else begin
      MODE_STROBE <= mode_go;
      if (mode_go) begin
        MODE_CMD <= mode_byte[6:0];
        SHORT_REF <= w_second;
        LONG_REF <= long_use;
      end
    end
  end

endmodule : dsc_top

/* inc/dsc_defines.svh */
// Contract
// - Rotation sense: 0 clockwise, 1 counter-clockwise, resets 0
// - Clockwise setting turns motor clockwise on positive speed
// - Changed rotation sense takes effect at next power-up
// - Restore bit 0 resets parameters, listed groups excepted
// - Restored values never written to nonvolatile memory
// - Factory defaults reset all, effective after power cycle
// - Cyclic registers need 32-bit access; 16-bit gives error
// - Cyclic writes need fieldbus channel assigned, not blocked
// - Control functions fire on rising edge only
// - Bit 8 disables, bit 9 enables; disable wins
// - Bit 10 quick stop beats bit 11 fault reset
// - Bit 13 halt beats 14 clear, 15 resume; 12 reserved
// - All-zero control field means power stage disable
// - Non-executable state requests ignored without answer
// - Mode fields evaluated only when toggle bit changed
// - All-zero mode byte skips data without error
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// Register addresses, in Modbus register units
`define DSC_ADDR_USER_RESTORE 16'h0410
`define DSC_ADDR_ROT_SENSE 16'h0618
`define DSC_ADDR_CMD_SHORT 16'h1B0A
`define DSC_ADDR_LONG_REF 16'h1B0C

// Register counts of one access
`define DSC_CNT_ONE 3'h1
`define DSC_CNT_PAIR 3'h2
`define DSC_CNT_BOTH 3'h4

// Field positions and limits
`define DSC_RESTORE_GO_BIT 0
`define DSC_RESTORE_MAX 16'h0007
`define DSC_ROT_MAX 16'h0001
`define DSC_ROT_RESET 1'h0
`define DSC_TOGGLE_BIT 7

// Operating state codes seen on DRIVE_STATE
`define DSC_ST_READY 4'h4
`define DSC_ST_SWITCHED_ON 4'h5
`define DSC_ST_OP_ENABLED 4'h6
`define DSC_ST_QSTOP_ACTIVE 4'h7
`define DSC_ST_FAULT 4'h9

`endif

/* inc/dsc_pkg.sv */
package dsc_pkg;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    DSC_IDLE = 2'b01,
    DSC_ANSWER = 2'b10
  } dsc_bus_type;

endpackage : dsc_pkg

/* verification/dsc_checker.sv */
`timescale 1ns/1ps
// Port-level timing checks of the command decoder
module dsc_checker (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Register access
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [2:0] REQ_COUNT,
  input wire logic [63:0] REQ_WDATA,
  input wire logic CHANNEL_OWNED,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic RSP_ERROR,
  // Status in, storage and rotation out
  input wire logic [3:0] DRIVE_STATE,
  input wire logic SPEED_NEG,
  input wire logic NV_SAVE,
  input wire logic USER_RESTORE,
  input wire logic ROT_SENSE_EFFECTIVE,
  input wire logic MOTOR_CW,
  // Drive-control pulses
  input wire logic POWER_STAGE_OFF,
  input wire logic POWER_STAGE_ON,
  input wire logic QUICK_STOP_REQUEST,
  input wire logic FAULT_CLEAR_REQUEST,
  input wire logic HALT_SET,
  input wire logic HALT_CLEAR,
  input wire logic HALT_RESUME
);
  // Request taken at this edge
  wire taken = REQ_VALID && REQ_READY;
  // Well-formed command word write
  wire cmd_wr = taken && REQ_WRITE && REQ_ADDR == 16'h1B0A &&
    (REQ_COUNT == 3'h2 || REQ_COUNT == 3'h4);
  // Any control pulse
  wire any_pulse = POWER_STAGE_OFF | POWER_STAGE_ON | QUICK_STOP_REQUEST |
    FAULT_CLEAR_REQUEST | HALT_SET | HALT_CLEAR | HALT_RESUME;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_short_access_err: assert property (
    taken && REQ_ADDR == 16'h1B0A && REQ_COUNT == 3'h1 |=>
    RSP_VALID && RSP_ERROR) else $error("short cyclic access accepted");
  a_channel_gate: assert property (
    taken && REQ_WRITE && !CHANNEL_OWNED && REQ_ADDR == 16'h1B0A |=>
    RSP_ERROR && !any_pulse) else $error("write without channel taken");
  a_pulse_on_write: assert property (
    any_pulse |-> RSP_VALID && !RSP_ERROR && $past(cmd_wr && CHANNEL_OWNED))
    else $error("control pulse without command write");
  a_pulse_single: assert property (
    any_pulse |=> !any_pulse) else $error("control pulse repeated");
  a_off_over_on: assert property (
    POWER_STAGE_OFF |-> !POWER_STAGE_ON) else $error("enable beside disable");
  a_qstop_over_reset: assert property (
    QUICK_STOP_REQUEST |-> !FAULT_CLEAR_REQUEST)
    else $error("fault reset beside quick stop");
  a_halt_wins: assert property (
    HALT_SET |-> !HALT_CLEAR && !HALT_RESUME) else $error("halt not first");
  a_zero_field_off: assert property (
    cmd_wr && CHANNEL_OWNED && REQ_WDATA[63:56] == 8'h00 &&
    DRIVE_STATE == 4'h6 |=> POWER_STAGE_OFF) else $error("zero field kept on");
  a_ignore_silent: assert property (
    cmd_wr && CHANNEL_OWNED && DRIVE_STATE == 4'h4 |=>
    !QUICK_STOP_REQUEST && !RSP_ERROR) else $error("bad request answered");
  a_motor_sense: assert property (
    MOTOR_CW == (!$past(SPEED_NEG) ^ $past(ROT_SENSE_EFFECTIVE)))
    else $error("motor direction wrong");
  a_sense_fixed: assert property (
    $past(RST_N, 4) |-> $stable(ROT_SENSE_EFFECTIVE))
    else $error("rotation sense changed while running");
  a_restore_no_save: assert property (
    taken && REQ_WRITE && REQ_ADDR == 16'h0410 && REQ_COUNT == 3'h1 &&
    REQ_WDATA[63:48] == 16'h0001 |=> USER_RESTORE && !NV_SAVE && !RSP_ERROR)
    else $error("restore wrong");
endmodule : dsc_checker

bind dsc_top dsc_checker dsc_checker_inst (
  .MCLK, .RST_N, .REQ_VALID, .REQ_WRITE, .REQ_ADDR, .REQ_COUNT,
  .REQ_WDATA, .CHANNEL_OWNED, .REQ_READY, .RSP_VALID, .RSP_ERROR,
  .DRIVE_STATE, .SPEED_NEG, .NV_SAVE, .USER_RESTORE,
  .ROT_SENSE_EFFECTIVE, .MOTOR_CW, .POWER_STAGE_OFF, .POWER_STAGE_ON,
  .QUICK_STOP_REQUEST, .FAULT_CLEAR_REQUEST, .HALT_SET, .HALT_CLEAR,
  .HALT_RESUME
);

/* verification/dsc_ctrl_model.sv */
`timescale 1ns/1ps
// Fieldbus controller: one register access at a time
module dsc_ctrl_model (
  // Clock
  input wire logic mclk,
  // Answer from the drive
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic [15:0] rsp_rdata,
  // Request to the drive
  output logic req_valid,
  output logic req_write,
  output logic [15:0] req_addr,
  output logic [2:0] req_count,
  output logic [63:0] req_wdata
);
  // Idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_count = 3'h0;
    req_wdata = 64'h0000_0000_0000_0000;
  end

  // Hold the request until taken, then collect the answer
  task automatic access(input logic w, input logic [15:0] a,
      input logic [2:0] c, input logic [63:0] d,
      output logic e, output logic [15:0] r);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_count <= c;
    req_wdata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    // Released lines show the inverse, never the old value
    req_valid <= 1'b0;
    req_write <= ~w;
    req_addr <= ~a;
    req_count <= ~c;
    req_wdata <= ~d;
    @(posedge mclk);
    // Missing answer reads as unknown
    e = rsp_valid === 1'b1 ? rsp_error : 1'bx;
    r = rsp_rdata;
  endtask : access
endmodule : dsc_ctrl_model

/* verification/test_drive_io_scan_command_decoder.sv */
`timescale 1ns/1ps
// Self-checking bench with a behavioural decoder model
module test_drive_io_scan_command_decoder;
  // Clock, reset and drive-side inputs
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic channel_owned = 1'b1;
  logic nv_rot_sense = 1'b0;
  logic factory_req = 1'b0;
  logic [3:0] drive_state = 4'h6;
  logic speed_neg = 1'b0;
  // Bus between controller model and design
  logic req_valid, req_write, req_ready, rsp_valid, rsp_error;
  logic [15:0] req_addr, rsp_rdata;
  logic [2:0] req_count;
  logic [63:0] req_wdata;
  // Design outputs; pulses are off,on,stop,clr,hset,hclr,hres
  logic nv_save, nv_save_rot, user_restore, factory_restore, reboot;
  logic rot_eff, motor_cw, mode_strobe;
  logic [6:0] pulses, mode_cmd;
  logic [15:0] short_ref;
  logic [31:0] long_ref;
  // Counters and model state
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] m_prev;
  logic m_tog;
  logic [31:0] m_long;
  // Operating states and refused accesses
  logic [3:0] states [5] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h9};
  logic ew [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [15:0] ea [7] = '{16'h1B0A, 16'h1B0A, 16'h1B0C, 16'h0410,
    16'h0618, 16'h1234, 16'h0410};
  logic [2:0] ec [7] = '{3'h1, 3'h2, 3'h4, 3'h2, 3'h1, 3'h1, 3'h1};

  dsc_top dsc_top_inst (
    .MCLK(mclk), .RST_N(rst_n), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_COUNT(req_count),
    .REQ_WDATA(req_wdata), .CHANNEL_OWNED(channel_owned),
    .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_ERROR(rsp_error),
    .RSP_RDATA(rsp_rdata), .NV_ROT_SENSE(nv_rot_sense),
    .FACTORY_REQ(factory_req), .DRIVE_STATE(drive_state),
    .SPEED_NEG(speed_neg), .NV_SAVE(nv_save),
    .NV_SAVE_ROT_SENSE(nv_save_rot), .USER_RESTORE(user_restore),
    .FACTORY_RESTORE(factory_restore), .REBOOT_PENDING(reboot),
    .ROT_SENSE_EFFECTIVE(rot_eff), .MOTOR_CW(motor_cw),
    .POWER_STAGE_OFF(pulses[6]), .POWER_STAGE_ON(pulses[5]),
    .QUICK_STOP_REQUEST(pulses[4]), .FAULT_CLEAR_REQUEST(pulses[3]),
    .HALT_SET(pulses[2]), .HALT_CLEAR(pulses[1]), .HALT_RESUME(pulses[0]),
    .MODE_STROBE(mode_strobe), .MODE_CMD(mode_cmd),
    .SHORT_REF(short_ref), .LONG_REF(long_ref)
  );

  dsc_ctrl_model dsc_ctrl_model_inst (
    .mclk(mclk), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_count(req_count),
    .req_wdata(req_wdata)
  );

  // Clock and hang guard
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      n_fail++;
      finish_test();
    end
  end

  // Compare and report
  task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Reset as a power-up, model cleared alike
  task automatic do_reset(input logic nv);
    rst_n <= 1'b0;
    nv_rot_sense <= nv;
    speed_neg <= 1'b0;
    m_prev = 8'h00;
    m_tog = 1'b0;
    m_long = 32'h0000_0000;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    // Power-up capture lands on the third edge after release
    repeat (4) @(posedge mclk);
  endtask : do_reset

  // One access with its expected error answer
  task automatic acc(input logic w, input logic [15:0] a,
      input logic [2:0] c, input logic [63:0] d, input logic ee,
      output logic [15:0] r);
    logic e;
    dsc_ctrl_model_inst.access(w, a, c, d, e, r);
    check("rsp_error", e, ee);
  endtask : acc

  // Expected control pulses from new and previous bytes
  function automatic logic [6:0] exp_pulse(logic [7:0] n, logic [7:0] p,
      logic [3:0] s);
    logic [7:0] r;
    logic off;
    r = n & ~p;
    off = r[0] || n == 8'h00;
    return {off && s inside {4'h5, 4'h6, 4'h7},
      r[1] && !off && s inside {4'h4, 4'h5}, r[2] && s == 4'h6,
      r[3] && !r[2] && s inside {4'h7, 4'h9}, r[5] && s == 4'h6,
      r[6] && !r[5] && s == 4'h6, r[7] && !r[5] && s == 4'h6};
  endfunction : exp_pulse

  // Command write compared with the model
  task automatic cmd(input logic [7:0] ctl, input logic [3:0] st,
      input logic own, input logic [2:0] c);
    logic [15:0] r;
    logic [7:0] mb;
    logic [15:0] sr;
    logic [31:0] lr;
    logic strobe;
    logic [6:0] ep;
    mb = 8'($urandom);
    sr = 16'($urandom);
    lr = 32'($urandom);
    drive_state <= st;
    channel_owned <= own;
    strobe = mb[7] != m_tog && mb != 8'h00;
    ep = own ? exp_pulse(ctl, m_prev, st) : 7'h00;
    acc(1'b1, 16'h1B0A, c, {ctl, mb, sr, lr}, !own, r);
    check("pulses", pulses, ep);
    check("strobe", mode_strobe, own && strobe);
    if (own) begin
      if (c == 3'h4) m_long = lr;
      if (strobe) begin
        check("mode", {mode_cmd, short_ref, long_ref},
          {mb[6:0], sr, m_long});
      end
      m_prev = ctl;
      m_tog = mb[7];
    end
  endtask : cmd

  // Speed sign to turning sense
  task automatic dir_chk(input logic sn, input logic exp);
    speed_neg <= sn;
    repeat (2) @(posedge mclk);
    check("motor_cw", motor_cw, exp);
  endtask : dir_chk

  // Verdict
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    logic [15:0] r;
    logic [7:0] ctl;
    logic [3:0] st;
    int n;
    void'($urandom(59340));
    do_reset(1'b0);
    // Refused accesses leave no trace
    for (int i = 0; i < 7; i++) begin
      acc(ew[i], ea[i], ec[i], 64'h0008_0000_0000_0000, 1'b1, r);
      check("side effect", {pulses, user_restore, nv_save},
        9'h000);
    end
    acc(1'b1, 16'h0410, 3'h1, 64'h0001_0000_0000_0000, 1'b0, r);
    check("restore", {user_restore, nv_save}, 2'b10);
    acc(1'b0, 16'h0410, 3'h1, 64'h0, 1'b0, r);
    check("restore read", r, 16'h0001);
    m_long = 32'($urandom);
    acc(1'b1, 16'h1B0C, 3'h2, {m_long, 32'h0000_0000}, 1'b0, r);
    cmd(8'h00, 4'h6, 1'b1, 3'h2);
    cmd(8'hFF, 4'h6, 1'b1, 3'h2);
    // Random command traffic, some words repeated
    for (int i = 0; i < 80; i++) begin
      ctl = (i % 4 == 0) ? m_prev : 8'($urandom);
      st = states[$urandom_range(0, 4)];
      // Off/on and stop/clr both-edge pairs go to a state where the losing half could act
      if ((ctl & ~m_prev & 8'h03) == 8'h03) st = 4'h5;
      if ((ctl & ~m_prev & 8'h0C) == 8'h0C) st = 4'h9;
      cmd(ctl, st, $urandom_range(0, 7) != 0,
        $urandom_range(0, 1) ? 3'h4 : 3'h2);
    end
    // Rotation sense: stored now, effective at power-up
    acc(1'b0, 16'h0618, 3'h1, 64'h0, 1'b0, r);
    check("rot reset", r, 16'h0000);
    acc(1'b1, 16'h0618, 3'h1, 64'h0001_0000_0000_0000, 1'b0, r);
    check("rot save", {nv_save, nv_save_rot, rot_eff}, 3'b110);
    acc(1'b0, 16'h0618, 3'h1, 64'h0, 1'b0, r);
    check("rot read", {r, reboot}, 17'h0_0003);
    dir_chk(1'b1, 1'b0);
    do_reset(1'b1);
    check("rot eff", rot_eff, 1'b1);
    dir_chk(1'b1, 1'b1);
    dir_chk(1'b0, 1'b0);
    // Factory defaults
    factory_req <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (factory_restore !== 1'b1 && n < 8);
    check("factory", {factory_restore, nv_save, nv_save_rot, rot_eff},
      4'b1101);
    factory_req <= 1'b0;
    acc(1'b0, 16'h0618, 3'h1, 64'h0, 1'b0, r);
    check("rot after factory", {r, rot_eff}, 17'h0_0001);
    finish_test();
  end
endmodule : test_drive_io_scan_command_decoder
